// ---- fdp_defs.svh ----
`ifndef FDP_DEFS_SVH
`define FDP_DEFS_SVH

// Register byte offsets
`define FDP_OFS_DOR 8'h00
`define FDP_OFS_TDR 8'h04
`define FDP_OFS_CFG 8'h08
`define FDP_OFS_CTRL 8'h0C
`define FDP_OFS_STEP 8'h10
`define FDP_OFS_WDATA 8'h14
`define FDP_OFS_STATUS 8'h18
`define FDP_OFS_ISTAT 8'h1C
`define FDP_OFS_IMASK 8'h20

// digital_output_reg fields
`define FDP_DOR_SEL 0
`define FDP_DOR_SEL_EN 2
`define FDP_DOR_MOTOR 4

// tape_drive_reg field boot_drive_map
`define FDP_TDR_BOOT 0

// floppy_config_one field drive_quantity_bit
`define FDP_CFG_QTY 0

// Control register fields
`define FDP_CTRL_SIDE 0
`define FDP_CTRL_DIR_IN 1
`define FDP_CTRL_WGATE 2
`define FDP_CTRL_DENS_LO 3
`define FDP_CTRL_DENS_HI 4
`define FDP_CTRL_PRECOMP 5

// Status register fields
`define FDP_ST_MEDIA 0
`define FDP_ST_TRACK_ZERO_IN 1
`define FDP_ST_INDEX 2
`define FDP_ST_WP 3
`define FDP_ST_READ 4
`define FDP_ST_STEP_BUSY 5
`define FDP_ST_HOLD_FULL 6
`define FDP_ST_WGATE 7

// Interrupt event bits
`define FDP_EV_STEP_DONE 0
`define FDP_EV_HOLD_EMPTY 1
`define FDP_EV_INDEX 2
`define FDP_EV_MEDIA 3
`define FDP_EV_READ 4

// Reset values
`define FDP_RST_DOR 8'h00
`define FDP_RST_TDR 8'h00
`define FDP_RST_CFG 8'h00
`define FDP_RST_CTRL 8'h00
`define FDP_RST_IMASK 8'h00

// Timing
`define FDP_CLK_PERIOD_NS 10
`define FDP_STEP_PULSE_NS 1000
`define FDP_STEP_PERIOD_US 3000
`define FDP_CELL_NS 1000
`define FDP_WR_PULSE_NS 250
`define FDP_PULSE_BASE_NS 400
`define FDP_PRECOMP_UNIT_NS 40
`define FDP_STEP_PULSE_CYC ((`FDP_STEP_PULSE_NS + `FDP_CLK_PERIOD_NS - 1) / `FDP_CLK_PERIOD_NS)
`define FDP_STEP_PERIOD_CYC ((`FDP_STEP_PERIOD_US * 1000 + `FDP_CLK_PERIOD_NS - 1) / `FDP_CLK_PERIOD_NS)
`define FDP_CELL_CYC (`FDP_CELL_NS / `FDP_CLK_PERIOD_NS)
`define FDP_WR_PULSE_CYC ((`FDP_WR_PULSE_NS + `FDP_CLK_PERIOD_NS - 1) / `FDP_CLK_PERIOD_NS)
`define FDP_PULSE_BASE_CYC (`FDP_PULSE_BASE_NS / `FDP_CLK_PERIOD_NS)
`define FDP_PRECOMP_UNIT_CYC (`FDP_PRECOMP_UNIT_NS / `FDP_CLK_PERIOD_NS)

`endif

// ---- fdp_pkg.sv ----
package fdp_pkg;
  typedef enum logic [1:0] {
    FDP_STEP_IDLE,
    FDP_STEP_PULSE,
    FDP_STEP_WAIT
  } fdp_step_state_t;
  typedef logic [7:0] fdp_reg_t;
endpackage

// ---- fdp_sync.sv ----
`timescale 1ns/10ps
module fdp_sync #(
  parameter int W = 5,
  parameter logic [4:0] INIT = 5'h00
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Raw and filtered levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;
  wire [W-1:0] q_d = (s2_q & s3_q) | (q_q & (s2_q ^ s3_q));

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_q <= INIT[W-1:0];
      s2_q <= INIT[W-1:0];
      s3_q <= INIT[W-1:0];
      q_q <= INIT[W-1:0];
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= q_d;
    end
  end

  assign q = q_q;
endmodule

// ---- fdp_pin_if.sv ----
// Overview of operation
// - Side output low selects side one
// - Seek issues step pulses, one per track
// - Direction asserted moves head toward centre
// - Write gate asserted only while recording
// - MFM write stream with selectable precompensation
// - Media change level readable in status
// - Density outputs follow programmed values
// - Drive b motor from remapped motor bits in two-drive mode, from select enable in four-drive mode
// - Drive b select from remapped select bits
// - Drive a motor from remapped motor bits
// - Drive a select from remapped select bits
// - Quantity bit picks two- or four-drive pins
// - Four-drive mode drives external decoder controls
`timescale 1ns/10ps
`include "fdp_defs.svh"
module fdp_pin_if #(
  parameter int unsigned STEP_PERIOD_CYC = `FDP_STEP_PERIOD_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq,
  // Drive status inputs, all but media change active low
  input wire logic read_stream_in,
  input wire logic track_zero_in,
  input wire logic index_mark_in,
  input wire logic write_protect_in_n,
  input wire logic media_change_in,
  // Head and data outputs
  output logic write_stream_out,
  output logic side_choice,
  output logic track_pulse_n,
  output logic inward_move_n,
  output logic write_gate_n,
  // Density outputs
  output logic density_select_low,
  output logic density_select_high,
  // Shared motor and select pins
  output logic motor_on_drive_b_n,
  output logic select_drive_b_n,
  output logic motor_on_drive_a_n,
  output logic select_drive_a_n
);
  import fdp_pkg::*;

  localparam logic [18:0] STEP_PER_M1 = 19'(STEP_PERIOD_CYC - 1);
  localparam logic [18:0] STEP_PW_M1 = 19'(`FDP_STEP_PULSE_CYC - 1);
  localparam logic [6:0] CELL_M1 = 7'(`FDP_CELL_CYC - 1);
  localparam logic [4:0] WR_PW = 5'(`FDP_WR_PULSE_CYC);
  localparam logic [6:0] PBASE = 7'(`FDP_PULSE_BASE_CYC);
  localparam logic [2:0] PUNIT = 3'(`FDP_PRECOMP_UNIT_CYC);

  // Synchronised drive inputs
  logic [4:0] sync_q;
  fdp_sync #(
    .W(5),
    .INIT(5'h0F)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .d({media_change_in, write_protect_in_n, index_mark_in, track_zero_in, read_stream_in}),
    .q(sync_q)
  );
  wire read_act = ~sync_q[0];
  wire track_zero_in_act = ~sync_q[1];
  wire index_act = ~sync_q[2];
  wire wp_act = ~sync_q[3];
  wire media_act = sync_q[4];

  // Register state
  fdp_reg_t dor_q;
  fdp_reg_t tdr_q;
  fdp_reg_t cfg_q;
  fdp_reg_t ctrl_q;
  fdp_reg_t imask_q;
  fdp_reg_t ist_q;
  logic ack_q;
  logic [31:0] dat_q;

  // Bus decode
  wire [7:0] adr_w = {wb_adr_i[7:2], 2'b00};
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire rd = req & ~wb_we_i;
  wire hit_dor = adr_w == `FDP_OFS_DOR;
  wire hit_tdr = adr_w == `FDP_OFS_TDR;
  wire hit_cfg = adr_w == `FDP_OFS_CFG;
  wire hit_ctrl = adr_w == `FDP_OFS_CTRL;
  wire hit_step = adr_w == `FDP_OFS_STEP;
  wire hit_wdata = adr_w == `FDP_OFS_WDATA;
  wire hit_status = adr_w == `FDP_OFS_STATUS;
  wire hit_istat = adr_w == `FDP_OFS_ISTAT;
  wire hit_imask = adr_w == `FDP_OFS_IMASK;
  wire step_wr = wr & hit_step;
  wire wdata_wr = wr & hit_wdata;
  wire istat_rd = rd & hit_istat;

  // Stepper state
  fdp_step_state_t st_q;
  logic [7:0] steps_q;
  logic [18:0] stmr_q;
  logic dir_q;
  logic step_done;

  // Writer state
  logic gate_q;
  logic [6:0] cell_q;
  logic [7:0] hold_q;
  logic hold_full_q;
  logic [7:0] shf_q;
  logic [2:0] bit_q;
  logic phase_q;
  logic prev_q;
  logic [4:0] win_q;
  logic pend_q;
  logic [6:0] off_q;
  logic [4:0] pw_q;
  logic wout_q;
  logic hold_taken;

  // Status byte
  wire [7:0] status_w = {
    gate_q,
    hold_full_q,
    st_q != FDP_STEP_IDLE,
    read_act,
    wp_act,
    index_act,
    track_zero_in_act,
    media_act
  };

  wire [7:0] rd_mux =
    hit_dor ? dor_q :
    hit_tdr ? tdr_q :
    hit_cfg ? cfg_q :
    hit_ctrl ? ctrl_q :
    hit_step ? steps_q :
    hit_wdata ? hold_q :
    hit_status ? status_w :
    hit_istat ? ist_q :
    hit_imask ? imask_q :
    8'h00;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= rd ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dor_q <= `FDP_RST_DOR;
      tdr_q <= `FDP_RST_TDR;
      cfg_q <= `FDP_RST_CFG;
      ctrl_q <= `FDP_RST_CTRL;
      imask_q <= `FDP_RST_IMASK;
    end else if (wr) begin
      if (hit_dor) dor_q <= wb_dat_i[7:0];
      if (hit_tdr) tdr_q <= wb_dat_i[7:0];
      if (hit_cfg) cfg_q <= wb_dat_i[7:0];
      if (hit_ctrl) ctrl_q <= wb_dat_i[7:0];
      if (hit_imask) imask_q <= wb_dat_i[7:0];
    end
  end

  // Events and sticky interrupt status
  logic index_d_q;
  logic media_d_q;
  logic read_d_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      index_d_q <= 1'b0;
      media_d_q <= 1'b0;
      read_d_q <= 1'b0;
    end else begin
      index_d_q <= index_act;
      media_d_q <= media_act;
      read_d_q <= read_act;
    end
  end

  wire [7:0] ev = {
    3'b000,
    read_act & ~read_d_q,
    media_act & ~media_d_q,
    index_act & ~index_d_q,
    hold_taken,
    step_done
  };
  // Set beats a clearing read in the same cycle
  wire [7:0] ist_d = (ist_q & ~(istat_rd ? 8'hFF : 8'h00)) | ev;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ist_q <= 8'h00;
    end else begin
      ist_q <= ist_d;
    end
  end

  assign irq = |(ist_q & imask_q);

  // Stepper
  wire [7:0] step_cnt_w = wb_dat_i[7:0];
  wire stmr_end = stmr_q == STEP_PER_M1;
  wire spw_end = stmr_q == STEP_PW_M1;
  assign step_done = (st_q == FDP_STEP_WAIT) & stmr_end & (steps_q == 8'h01);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= FDP_STEP_IDLE;
      steps_q <= 8'h00;
      stmr_q <= 19'h0_0000;
      dir_q <= 1'b0;
    end else begin
      unique case (st_q)
        FDP_STEP_IDLE: begin
          if (step_wr && step_cnt_w != 8'h00) begin
            steps_q <= step_cnt_w;
            dir_q <= ctrl_q[`FDP_CTRL_DIR_IN];
            stmr_q <= 19'h0_0000;
            st_q <= FDP_STEP_PULSE;
          end
        end
        FDP_STEP_PULSE: begin
          stmr_q <= stmr_q + 19'h0_0001;
          if (spw_end) st_q <= FDP_STEP_WAIT;
        end
        FDP_STEP_WAIT: begin
          stmr_q <= stmr_q + 19'h0_0001;
          if (stmr_end) begin
            stmr_q <= 19'h0_0000;
            steps_q <= steps_q - 8'h01;
            st_q <= (steps_q == 8'h01) ? FDP_STEP_IDLE : FDP_STEP_PULSE;
          end
        end
      endcase
    end
  end

  assign track_pulse_n = st_q != FDP_STEP_PULSE;
  assign inward_move_n = ~dir_q;

  // Writer cell timing
  wire gate_d = ctrl_q[`FDP_CTRL_WGATE] & ~wp_act;
  wire cell_tick = gate_q & (cell_q == CELL_M1);
  wire byte_end = cell_tick & phase_q & (bit_q == 3'h7);
  assign hold_taken = byte_end & hold_full_q;

  // MFM cell: clock cell set only between two zero data bits
  wire new_cell = phase_q ? shf_q[7] : (~prev_q & ~shf_q[7]);
  wire [4:0] win_d = {new_cell, win_q[4:1]};
  wire early = win_d[4] & ~win_d[0];
  wire late = win_d[0] & ~win_d[4];
  wire [6:0] pc_w = 7'(ctrl_q[`FDP_CTRL_PRECOMP +: 3]) * 7'(PUNIT);
  wire [6:0] off_d = early ? PBASE - pc_w : late ? PBASE + pc_w : PBASE;
  wire pstart = gate_q & pend_q & (cell_q == off_q);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gate_q <= 1'b0;
      cell_q <= 7'h00;
    end else begin
      gate_q <= gate_d;
      cell_q <= (!gate_q || cell_tick) ? 7'h00 : cell_q + 7'h01;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
    end else begin
      if (wdata_wr && !hold_full_q) begin
        hold_q <= wb_dat_i[7:0];
        hold_full_q <= 1'b1;
      end else if (hold_taken) begin
        hold_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      shf_q <= 8'h00;
      bit_q <= 3'h0;
      phase_q <= 1'b0;
      prev_q <= 1'b0;
      win_q <= 5'h00;
      pend_q <= 1'b0;
      off_q <= 7'h00;
    end else if (!gate_q) begin
      shf_q <= 8'h00;
      bit_q <= 3'h0;
      phase_q <= 1'b0;
      prev_q <= 1'b0;
      win_q <= 5'h00;
      pend_q <= 1'b0;
    end else if (cell_tick) begin
      win_q <= win_d;
      pend_q <= win_d[2];
      off_q <= off_d;
      phase_q <= ~phase_q;
      if (phase_q) begin
        prev_q <= shf_q[7];
        bit_q <= bit_q + 3'h1;
        shf_q <= (bit_q == 3'h7) ? (hold_full_q ? hold_q : 8'h00) : {shf_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pw_q <= 5'h00;
      wout_q <= 1'b1;
    end else begin
      pw_q <= pstart ? WR_PW : (pw_q != 5'h00) ? pw_q - 5'h01 : 5'h00;
      wout_q <= !(pstart || pw_q > 5'h01);
    end
  end

  assign write_stream_out = wout_q;
  assign write_gate_n = ~gate_q;

  // Head side and density
  assign side_choice = ~ctrl_q[`FDP_CTRL_SIDE];
  assign density_select_low = ctrl_q[`FDP_CTRL_DENS_LO];
  assign density_select_high = ctrl_q[`FDP_CTRL_DENS_HI];

  // Drive select and motor remapping
  wire [1:0] boot = tdr_q[`FDP_TDR_BOOT +: 2];
  wire [3:0] motor = dor_q[`FDP_DOR_MOTOR +: 4];
  wire [1:0] phys_sel = dor_q[`FDP_DOR_SEL +: 2] ^ boot;
  wire sel_en = dor_q[`FDP_DOR_SEL_EN];
  wire [3:0] motor_phys = {
    motor[2'h3 ^ boot],
    motor[2'h2 ^ boot],
    motor[2'h1 ^ boot],
    motor[2'h0 ^ boot]
  };
  wire four = cfg_q[`FDP_CFG_QTY];

  wire two_mot_b_n = ~motor_phys[1];
  wire two_sel_b_n = ~(sel_en & (phys_sel == 2'h1));
  wire two_mot_a_n = ~motor_phys[0];
  wire two_sel_a_n = ~(sel_en & (phys_sel == 2'h0));

  wire decoder_select_enable_n = ~sel_en;
  wire motor_pick_high = phys_sel[1];
  wire motor_enable_gate_n = ~(sel_en & motor_phys[phys_sel]);
  wire motor_pick_low = phys_sel[0];

  logic [3:0] pins_q;
  wire [3:0] pins_d = four ?
    {decoder_select_enable_n, motor_pick_high, motor_enable_gate_n, motor_pick_low} :
    {two_mot_b_n, two_sel_b_n, two_mot_a_n, two_sel_a_n};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pins_q <= 4'hF;
    end else begin
      pins_q <= pins_d;
    end
  end

  assign motor_on_drive_b_n = pins_q[3];
  assign select_drive_b_n = pins_q[2];
  assign motor_on_drive_a_n = pins_q[1];
  assign select_drive_a_n = pins_q[0];
endmodule

// ---- fdp_drive_model.sv ----
`timescale 1ns/10ps
module fdp_drive_model (
  // Head control from the device
  input wire logic mclk,
  input wire logic track_pulse_n,
  input wire logic inward_move_n,
  // Media events commanded by the bench
  input wire logic wp_on,
  input wire logic door_open,
  input wire logic idx_kick,
  input wire logic rd_kick,
  // Drive status lines
  output logic read_stream_in,
  output logic track_zero_in,
  output logic index_mark_in,
  output logic write_protect_in_n,
  output logic media_change_in,
  output int track
);
  logic step_q = 1'b1;
  initial track = 0;
  // Head moves one track at each step pulse front, except outward at track zero where it holds
  always @(posedge mclk) begin
    step_q <= track_pulse_n;
    if (step_q && !track_pulse_n && !inward_move_n)
      track <= track + 1;
    else if (step_q && !track_pulse_n && track > 0)
      track <= track - 1;
  end
  assign read_stream_in = !rd_kick;
  assign track_zero_in = track != 0;
  assign index_mark_in = !idx_kick;
  assign write_protect_in_n = !wp_on;
  assign media_change_in = door_open;
endmodule

// ---- fdp_pin_if_chk.sv ----
`timescale 1ns/10ps
module fdp_pin_if_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  // Drive pins
  input wire logic write_protect_in_n,
  input wire logic write_stream_out,
  input wire logic side_choice,
  input wire logic track_pulse_n,
  input wire logic inward_move_n,
  input wire logic write_gate_n,
  input wire logic density_select_low,
  input wire logic density_select_high,
  input wire logic motor_on_drive_b_n,
  input wire logic select_drive_b_n,
  input wire logic motor_on_drive_a_n,
  input wire logic select_drive_a_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  logic [2:0] ctrl_wr_q, any_wr_q;
  logic [7:0] step_lo_q, wr_lo_q;
  wire req = wb_cyc_i && wb_stb_i;
  wire any_wr = req && wb_we_i && wb_sel_i[0];
  wire ctrl_wr = any_wr && wb_adr_i[7:2] == 6'h03;
  wire [3:0] pins = {motor_on_drive_b_n, select_drive_b_n, motor_on_drive_a_n, select_drive_a_n};
  // Recent write history and low-time counters
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_wr_q <= 3'h0;
      any_wr_q <= 3'h0;
      step_lo_q <= 8'h00;
      wr_lo_q <= 8'h00;
    end else begin
      ctrl_wr_q <= {ctrl_wr_q[1:0], ctrl_wr};
      any_wr_q <= {any_wr_q[1:0], any_wr};
      step_lo_q <= track_pulse_n ? 8'h00 : step_lo_q + 8'h01;
      wr_lo_q <= write_stream_out ? 8'h00 : wr_lo_q + 8'h01;
    end
  end
  sequence taken;
    req && !wb_ack_o;
  endsequence
  sequence wp_held;
    !write_protect_in_n [*8];
  endsequence
  a_ack_follows: assert property (taken |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_side_by_ctrl: assert property ($changed(side_choice) |-> |ctrl_wr_q)
    else $error("side changed without control write");
  a_dens_by_ctrl: assert property ($changed({density_select_low, density_select_high}) |-> |ctrl_wr_q)
    else $error("density changed without control write");
  a_pins_by_reg: assert property ($changed(pins) |-> |any_wr_q)
    else $error("motor or select pin changed without write");
  a_step_width: assert property ($rose(track_pulse_n) |-> step_lo_q == 8'h64)
    else $error("step pulse width wrong");
  a_dir_held: assert property (!track_pulse_n && !$fell(track_pulse_n) |-> $stable(inward_move_n))
    else $error("direction moved during step pulse");
  a_gate_wp_off: assert property (wp_held |-> write_gate_n)
    else $error("write gate on protected media");
  a_wr_width: assert property ($rose(write_stream_out) |-> wr_lo_q == 8'h19)
    else $error("write pulse width wrong");
endmodule
bind fdp_pin_if fdp_pin_if_chk u_chk (.*);

// ---- fdp_pin_if_tb_top.sv ----
`timescale 1ns/10ps
module fdp_pin_if_tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rdq;
  logic ack, irq, wso, side, tp_n, in_n, wg_n, dl, dh, mb_n, sb_n, ma_n, sa_n, rs, tz, ix, wp_n, mc;
  logic wp_on = 1'b0, door_open = 1'b0, idx_kick = 1'b0, rd_kick = 1'b0;
  int track, n_mismatch = 0, checks_done = 0;

  always #5 mclk = ~mclk;

  fdp_pin_if #(.STEP_PERIOD_CYC(200)) u_fdp_pin_if (
    .mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .read_stream_in(rs),
    .track_zero_in(tz), .index_mark_in(ix), .write_protect_in_n(wp_n), .media_change_in(mc),
    .write_stream_out(wso), .side_choice(side), .track_pulse_n(tp_n), .inward_move_n(in_n),
    .write_gate_n(wg_n), .density_select_low(dl), .density_select_high(dh), .motor_on_drive_b_n(mb_n),
    .select_drive_b_n(sb_n), .motor_on_drive_a_n(ma_n), .select_drive_a_n(sa_n));
  fdp_drive_model u_fdp_drive_model (.mclk(mclk), .track_pulse_n(tp_n), .inward_move_n(in_n),
    .wp_on(wp_on), .door_open(door_open), .idx_kick(idx_kick), .rd_kick(rd_kick), .read_stream_in(rs),
    .track_zero_in(tz), .index_mark_in(ix), .write_protect_in_n(wp_n), .media_change_in(mc),
    .track(track));

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One classic cycle; read data lands in rdq
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
    rdq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask

  // Cycles until the next falling write pulse
  task automatic fall(output int n);
    n = 0;
    while (wso !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    while (wso !== 1'b0 && n < 400) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic t_reset();
    chk(32'({side, tp_n, in_n, wg_n, wso, dl, dh, mb_n, sb_n, ma_n, sa_n}), 32'h7CF);
    wb(1'b0, 8'h08, 8'h00);
    chk(rdq, 32'h0);
    wb(1'b1, 8'h3C, 8'h5A);
    wb(1'b0, 8'h3C, 8'h00);
    chk(rdq, 32'h0);
  endtask

  task automatic t_ctrl();
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, 8'h0C, {3'(i), i[2], i[1], 2'b00, i[0]});
      tick(3);
      chk(32'({side, dh, dl}), 32'({~i[0], i[2], i[1]}));
    end
  endtask

  task automatic t_pins();
    logic [1:0] p;
    logic [3:0] m, e;
    logic en;
    for (int k = 0; k < 32; k++) begin
      p = k[1:0] ^ k[3:2];
      m = 4'h6 ^ k[3:0];
      en = k[4] ? k[3] : 1'b1;
      wb(1'b1, 8'h08, 8'(k[4]));
      wb(1'b1, 8'h04, 8'(k[3:2]));
      wb(1'b1, 8'h00, {m, 1'b0, en, k[1:0]});
      tick(3);
      if (k[4])
        e = {~en, p[1], ~(en & m[k[1:0]]), p[0]};
      else
        e = {~m[2'h1 ^ k[3:2]], p != 2'h1, ~m[k[3:2]], p != 2'h0};
      chk(32'({mb_n, sb_n, ma_n, sa_n}), 32'(e));
    end
  endtask

  task automatic step_run(input logic inward, input int exp_trk);
    int n;
    logic lp;
    wb(1'b1, 8'h0C, {6'h00, inward, 1'b0});
    wb(1'b1, 8'h10, 8'h03);
    n = 0;
    lp = 1'b1;
    repeat (700) begin
      @(posedge mclk);
      if (lp === 1'b1 && tp_n === 1'b0)
        n++;
      lp = tp_n;
    end
    chk(n, 3);
    chk(track, exp_trk);
    chk(32'(in_n), 32'(!inward));
  endtask

  task automatic t_step();
    wb(1'b1, 8'h20, 8'h01);
    step_run(1'b1, 3);
    chk(32'(irq), 32'h1);
    wb(1'b0, 8'h1C, 8'h00);
    chk(rdq & 32'h1, 32'h1);
    tick(2);
    chk(32'(irq), 32'h0);
    wb(1'b1, 8'h20, 8'h00);
    step_run(1'b0, 0);
    chk(32'({irq, tz}), 32'h0);
    wb(1'b0, 8'h1C, 8'h00);
    chk(rdq & 32'h1, 32'h1);
  endtask

  task automatic t_events();
    door_open <= 1'b1;
    tick(10);
    wb(1'b0, 8'h18, 8'h00);
    chk(rdq & 32'h1, 32'h1);
    door_open <= 1'b0;
    rd_kick <= 1'b1;
    idx_kick <= 1'b1;
    tick(10);
    rd_kick <= 1'b0;
    idx_kick <= 1'b0;
    tick(10);
    wb(1'b0, 8'h1C, 8'h00);
    chk(rdq & 32'h1C, 32'h1C);
    wb(1'b0, 8'h18, 8'h00);
    chk(rdq & 32'h1, 32'h0);
  endtask

  task automatic t_write();
    int n;
    wb(1'b1, 8'h0C, 8'hE4);
    tick(10);
    chk(32'(wg_n), 32'h0);
    wb(1'b0, 8'h18, 8'h00);
    chk(rdq, 32'h82);
    tick(600);
    fall(n);
    fall(n);
    chk(n, 200);
    // Byte 0x20 after zero fill: one late and one early pulse
    wb(1'b1, 8'h14, 8'h20);
    fall(n);
    for (int i = 0; i < 40 && n != 228; i++)
      fall(n);
    chk(n, 228);
    fall(n);
    chk(n, 272);
    fall(n);
    chk(n, 272);
    fall(n);
    chk(n, 228);
    wb(1'b0, 8'h1C, 8'h00);
    chk(rdq & 32'h2, 32'h2);
    wp_on <= 1'b1;
    tick(10);
    chk(32'(wg_n), 32'h1);
    wb(1'b0, 8'h18, 8'h00);
    chk(rdq & 32'hC8, 32'h08);
    wb(1'b1, 8'h0C, 8'h00);
    wp_on <= 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_ctrl();
    t_pins();
    t_step();
    t_events();
    t_write();
    end_sim();
  end
endmodule
